// ---- src/sdvp_pkg.sv ----
// Constants for the SD copy-management and picture-adjust register bank
package sdvp_pkg;

  // Register subaddresses
  localparam logic [7:0] OFS_CM_CTRL    = 8'h99;
  localparam logic [7:0] OFS_CM_MID     = 8'h9a;
  localparam logic [7:0] OFS_CM_LOW     = 8'h9b;
  localparam logic [7:0] OFS_SCALE_LSB  = 8'h9c;
  localparam logic [7:0] OFS_LUMA_HI    = 8'h9d;
  localparam logic [7:0] OFS_CB_HI      = 8'h9e;
  localparam logic [7:0] OFS_CR_HI      = 8'h9f;
  localparam logic [7:0] OFS_HUE        = 8'ha0;
  localparam logic [7:0] OFS_BRIGHT     = 8'ha1;
  localparam logic [7:0] OFS_SHAPE_GAIN = 8'ha2;
  localparam logic [7:0] OFS_CORING     = 8'ha3;

  // Every register of the bank resets to this value
  localparam logic [7:0] REG_RESET      = 8'h00;
  // Unmapped subaddresses read as this value
  localparam logic [7:0] RD_UNMAPPED    = 8'h00;

  // Field positions in the copy-management control register
  localparam int CM_CHECKSUM_BIT = 4;
  localparam int CM_ODD_BIT      = 5;
  localparam int CM_EVEN_BIT     = 6;
  localparam int WSS_ENABLE_BIT  = 7;
  // Field position in the brightness register
  localparam int WSS_BLANK_BIT   = 7;

  // Writable bits of the shaping gain register, the rest reserved as zero
  localparam logic [7:0] SHAPE_WR_MASK = 8'h0f;

  // Shaping gain: code 0 is -4 dB, each code step is 2/3 dB (4 sixths)
  localparam logic [3:0] SHAPE_MAX_CODE  = 4'hc;
  localparam logic [6:0] SHAPE_STEP      = 7'h04;
  localparam logic [6:0] SHAPE_MIN_SIXTH = 7'h68;  // -24 sixths of a dB

  // Coring gain: codes above this clamp to it
  localparam logic [3:0] CORING_MAX_CODE = 4'h8;

endpackage : sdvp_pkg

// ---- src/sdvp_coring_decode.sv ----
// Decoder of one 4-bit coring gain code into sixteenths of unity
`timescale 1ns/10ps
module sdvp_coring_decode (
  // Code and mode
  input  wire logic              [3:0] code,
  input  wire logic                    nrMode,
  // Gain in 1/16 units, two's complement
  output      logic signed       [5:0] gainSixteenths
);
  import sdvp_pkg::*;

  logic [3:0] clamped;

  // Codes above eight are undefined; clamping keeps the gain bounded
  always_comb begin
    clamped = (code > CORING_MAX_CODE) ? CORING_MAX_CODE : code;
    if (nrMode) begin
      // Negative n/8, so code 8 gives -1
      gainSixteenths = -$signed({1'b0, clamped, 1'b0});
    end else begin
      gainSixteenths = $signed({2'b00, clamped});
    end
  end

endmodule : sdvp_coring_decode

// ---- src/sdvp_shaping_decode.sv ----
// Decoder of the luma shaping-filter gain code into sixths of a dB
`timescale 1ns/10ps
module sdvp_shaping_decode (
  // Code and external enable
  input  wire logic              [3:0] code,
  input  wire logic                    enable,
  // Gain in 1/6 dB units, two's complement
  output      logic signed       [6:0] gainSixthDb
);
  import sdvp_pkg::*;

  logic [3:0] clamped;
  logic [6:0] product;

  // Disabled filter gain is reported as 0 dB, the setting is ignored
  always_comb begin
    clamped = (code > SHAPE_MAX_CODE) ? SHAPE_MAX_CODE : code;
    product = 7'({3'b000, clamped} * SHAPE_STEP);
    if (enable) begin
      gainSixthDb = $signed(7'(product + SHAPE_MIN_SIXTH));
    end else begin
      gainSixthDb = 7'sh00;
    end
  end

endmodule : sdvp_shaping_decode

// ---- src/sdvp_regs.sv ----
// SD copy-management, signalling and picture-adjust register bank
// Summary of operation
// - Control bit 5 enables copy-management insertion on odd fields.
// - Control bit 6 enables copy-management insertion on even fields.
// - Upper payload bits 19:8 join control, mid-register high and low fields.
// - Mid bits 5:0 and the low register are shared copy-management / wide-screen data.
// - Luma scale is high register plus scale-LSB bits 1:0.
// - Blue-difference scale is its high register plus LSB bits 3:2.
// - Red-difference scale is its high register plus LSB bits 5:4.
// - Scale-LSB bits 7:6 are the subcarrier phase low bits.
// - Hue register holds an 8-bit hue adjust for chroma.
// - Shaping gain code 0 is -4 dB, 6 is 0 dB, 12 is +4 dB.
// - Shaping gain applies only while the external filter enable is set.
// - Coring codes 0..8 give +n/16 outside noise-reduction mode.
// - In noise-reduction mode coring codes give -n/8, code 8 gives -1.
`timescale 1ns/10ps
module sdvp_regs (
  // Clock and synchronous reset
  input  wire logic                    clk,
  input  wire logic                    rstn,
  // Serial-port subaddress access
  input  wire logic              [7:0] regAddr,
  input  wire logic                    regWrEn,
  input  wire logic              [7:0] regWrData,
  input  wire logic                    regRdEn,
  output      logic              [7:0] regRdData,
  output      logic                    regRdValid,
  // Video timing and mode inputs, same clock
  input  wire logic                    fieldOdd,
  input  wire logic                    shapingFilterEn,
  input  wire logic                    noiseReductionMode,
  // Copy-management and wide-screen signalling controls
  output      logic                    cmInsert,
  output      logic                    cmChecksumEn,
  output      logic             [19:0] cmPayload,
  output      logic                    wssInsert,
  output      logic                    wssBlank,
  output      logic             [13:0] wssPayload,
  // Picture adjust values
  output      logic              [9:0] lumaScale,
  output      logic              [9:0] cbScale,
  output      logic              [9:0] crScale,
  output      logic              [1:0] phaseLsb,
  output      logic              [7:0] hueAdjust,
  output      logic              [6:0] brightness,
  // Decoded gains
  output      logic signed       [6:0] shapingGain,
  output      logic signed       [5:0] coringBorderGain,
  output      logic signed       [5:0] coringDataGain
);
  import sdvp_pkg::*;

  // Whole block state, registers and registered outputs
  typedef struct packed {
    logic        [7:0] cmCtrl;
    logic        [7:0] cmMid;
    logic        [7:0] cmLow;
    logic        [7:0] scaleLsb;
    logic        [7:0] lumaHi;
    logic        [7:0] cbHi;
    logic        [7:0] crHi;
    logic        [7:0] hue;
    logic        [7:0] bright;
    logic        [7:0] shape;
    logic        [7:0] coring;
    logic        [7:0] rdData;
    logic              rdValid;
    logic              cmIns;
    logic              cmChk;
    logic       [19:0] cmPay;
    logic              wssIns;
    logic              wssBlk;
    logic       [13:0] wssPay;
    logic        [9:0] luma;
    logic        [9:0] cb;
    logic        [9:0] cr;
    logic        [1:0] phase;
    logic        [7:0] hueOut;
    logic        [6:0] brightOut;
    logic signed [6:0] shapeGain;
    logic signed [5:0] coreBorder;
    logic signed [5:0] coreData;
  } sdvp_state_s;

  sdvp_state_s       st_ff;
  sdvp_state_s       nxt_st;
  logic signed [6:0] shapeDec;
  logic signed [5:0] coreDec [2];
  logic       [87:0] regFile;

  // Shaping gain decode, gated by the external filter enable
  sdvp_shaping_decode uShape (
    .code        (st_ff.shape[3:0]),
    .enable      (shapingFilterEn),
    .gainSixthDb (shapeDec)
  );

  // Two identical coring decoders: border nibble and data nibble
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : gCore
      sdvp_coring_decode uCore (
        .code           (st_ff.coring[gi*4 +: 4]),
        .nrMode         (noiseReductionMode),
        .gainSixteenths (coreDec[gi])
      );
    end
  endgenerate

  // Read decode, shared by the read path and its check
  function automatic logic [7:0] rdMux(input sdvp_state_s s,
                                       input logic [7:0] a);
    case (a)
      OFS_CM_CTRL:    rdMux = s.cmCtrl;
      OFS_CM_MID:     rdMux = s.cmMid;
      OFS_CM_LOW:     rdMux = s.cmLow;
      OFS_SCALE_LSB:  rdMux = s.scaleLsb;
      OFS_LUMA_HI:    rdMux = s.lumaHi;
      OFS_CB_HI:      rdMux = s.cbHi;
      OFS_CR_HI:      rdMux = s.crHi;
      OFS_HUE:        rdMux = s.hue;
      OFS_BRIGHT:     rdMux = s.bright;
      OFS_SHAPE_GAIN: rdMux = s.shape;
      OFS_CORING:     rdMux = s.coring;
      default:        rdMux = RD_UNMAPPED;
    endcase
  endfunction : rdMux

  // Next state: register writes, read answer and derived outputs
  always_comb begin
    nxt_st = st_ff;
    // Reads return the value held before a same-cycle write
    nxt_st.rdValid = regRdEn;
    if (regRdEn) begin
      nxt_st.rdData = rdMux(st_ff, regAddr);
    end
    if (regWrEn) begin
      case (regAddr)
        OFS_CM_CTRL:    nxt_st.cmCtrl   = regWrData;
        OFS_CM_MID:     nxt_st.cmMid    = regWrData;
        OFS_CM_LOW:     nxt_st.cmLow    = regWrData;
        OFS_SCALE_LSB:  nxt_st.scaleLsb = regWrData;
        OFS_LUMA_HI:    nxt_st.lumaHi   = regWrData;
        OFS_CB_HI:      nxt_st.cbHi     = regWrData;
        OFS_CR_HI:      nxt_st.crHi     = regWrData;
        OFS_HUE:        nxt_st.hue      = regWrData;
        OFS_BRIGHT:     nxt_st.bright   = regWrData;
        // Reserved bits are forced so they always read back as zero
        OFS_SHAPE_GAIN: nxt_st.shape    = regWrData & SHAPE_WR_MASK;
        OFS_CORING:     nxt_st.coring   = regWrData;
        default:        nxt_st.cmCtrl   = st_ff.cmCtrl;
      endcase
    end
    // Field gating picks the odd or even enable for the current field
    nxt_st.cmIns = fieldOdd ? st_ff.cmCtrl[CM_ODD_BIT]
                            : st_ff.cmCtrl[CM_EVEN_BIT];
    nxt_st.cmChk  = st_ff.cmCtrl[CM_CHECKSUM_BIT];
    nxt_st.wssIns = st_ff.cmCtrl[WSS_ENABLE_BIT];
    nxt_st.wssBlk = st_ff.bright[WSS_BLANK_BIT];
    // Upper payload joins three fields
    nxt_st.cmPay = {st_ff.cmCtrl[3:0], st_ff.cmMid[7:6],
                    st_ff.cmMid[5:0], st_ff.cmLow};
    // One store feeds both services; the enabled one consumes it
    nxt_st.wssPay = {st_ff.cmMid[5:0], st_ff.cmLow};
    nxt_st.luma   = {st_ff.lumaHi, st_ff.scaleLsb[1:0]};
    nxt_st.cb     = {st_ff.cbHi, st_ff.scaleLsb[3:2]};
    nxt_st.cr     = {st_ff.crHi, st_ff.scaleLsb[5:4]};
    nxt_st.phase  = st_ff.scaleLsb[7:6];
    nxt_st.hueOut = st_ff.hue;
    nxt_st.brightOut  = st_ff.bright[6:0];
    nxt_st.shapeGain  = shapeDec;
    nxt_st.coreBorder = coreDec[0];
    nxt_st.coreData   = coreDec[1];
  end

  // State register; reset loads every register with its reset value
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_ff <= '0;
      st_ff.cmCtrl   <= REG_RESET;
      st_ff.cmMid    <= REG_RESET;
      st_ff.cmLow    <= REG_RESET;
      st_ff.scaleLsb <= REG_RESET;
      st_ff.lumaHi   <= REG_RESET;
      st_ff.cbHi     <= REG_RESET;
      st_ff.crHi     <= REG_RESET;
      st_ff.hue      <= REG_RESET;
      st_ff.bright   <= REG_RESET;
      st_ff.shape    <= REG_RESET;
      st_ff.coring   <= REG_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign regRdData        = st_ff.rdData;
  assign regRdValid       = st_ff.rdValid;
  assign cmInsert         = st_ff.cmIns;
  assign cmChecksumEn     = st_ff.cmChk;
  assign cmPayload        = st_ff.cmPay;
  assign wssInsert        = st_ff.wssIns;
  assign wssBlank         = st_ff.wssBlk;
  assign wssPayload       = st_ff.wssPay;
  assign lumaScale        = st_ff.luma;
  assign cbScale          = st_ff.cb;
  assign crScale          = st_ff.cr;
  assign phaseLsb         = st_ff.phase;
  assign hueAdjust        = st_ff.hueOut;
  assign brightness       = st_ff.brightOut;
  assign shapingGain      = st_ff.shapeGain;
  assign coringBorderGain = st_ff.coreBorder;
  assign coringDataGain   = st_ff.coreData;

  // All eleven registers in one word, watched by the reset and write checks
  assign regFile = {st_ff.cmCtrl, st_ff.cmMid, st_ff.cmLow, st_ff.scaleLsb,
                    st_ff.lumaHi, st_ff.cbHi, st_ff.crHi, st_ff.hue,
                    st_ff.bright, st_ff.shape, st_ff.coring};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Write steps used by several checks
  sequence sWrCtrlOdd;
    regWrEn && regAddr == OFS_CM_CTRL && regWrData[CM_ODD_BIT]
      && !regWrData[CM_EVEN_BIT];
  endsequence
  sequence sWrCtrlEven;
    regWrEn && regAddr == OFS_CM_CTRL && regWrData[CM_EVEN_BIT]
      && !regWrData[CM_ODD_BIT];
  endsequence
  sequence sNoCtrlWr;
    !(regWrEn && regAddr == OFS_CM_CTRL);
  endsequence

  a_odd_field_gate: assert property (
    sWrCtrlOdd ##1 (sNoCtrlWr and fieldOdd) |=> cmInsert
  ) else $error("odd field insertion not enabled");

  a_even_field_gate: assert property (
    sWrCtrlEven ##1 (sNoCtrlWr and fieldOdd) |=> !cmInsert
  ) else $error("even enable leaked into odd field");

  a_payload_join: assert property (
    cmPayload[19:8] == $past({st_ff.cmCtrl[3:0], st_ff.cmMid})
  ) else $error("copy-management upper payload misassembled");

  a_shared_store: assert property (
    cmPayload[13:0] == wssPayload
  ) else $error("shared data differs between services");

  a_luma_scale: assert property (
    regWrEn && regAddr == OFS_LUMA_HI
      |-> ##2 lumaScale[9:2] == $past(regWrData, 2)
  ) else $error("luma scale high bits not taken");

  a_chroma_scale: assert property (
    cbScale[1:0] == $past(st_ff.scaleLsb[3:2])
      && crScale[1:0] == $past(st_ff.scaleLsb[5:4])
  ) else $error("chroma scale low bits wrong");

  a_phase_hue: assert property (
    phaseLsb == $past(st_ff.scaleLsb[7:6]) && hueAdjust == $past(st_ff.hue)
  ) else $error("phase or hue value wrong");

  a_shape_gate: assert property (
    $past(!shapingFilterEn) |-> shapingGain == 7'sh00
  ) else $error("shaping gain applied while filter disabled");

  a_shape_zero: assert property (
    $past(shapingFilterEn && st_ff.shape[3:0] == 4'h6) |-> shapingGain == 0
  ) else $error("shaping code 6 is not 0 dB");

  a_coring_sign: assert property (
    $past(noiseReductionMode && st_ff.coring[3:0] == 4'h8)
      |-> coringBorderGain == -6'sd16
  ) else $error("noise-reduction code 8 is not -1");

  a_coring_plain: assert property (
    $past(!noiseReductionMode && st_ff.coring[7:4] == 4'h3)
      |-> coringDataGain == 6'sd3
  ) else $error("coring gain outside noise reduction wrong");

  a_reserved_read: assert property (
    regRdEn && regAddr == OFS_SHAPE_GAIN |=> regRdValid && regRdData[7:4] == 0
  ) else $error("reserved shaping bits read nonzero");

  a_signal_ctrl: assert property (
    wssInsert == $past(st_ff.cmCtrl[WSS_ENABLE_BIT])
      && wssBlank == $past(st_ff.bright[WSS_BLANK_BIT])
  ) else $error("signalling enable or blank wrong");

  a_checksum_bit: assert property (
    cmChecksumEn == $past(st_ff.cmCtrl[CM_CHECKSUM_BIT])
      && brightness == $past(st_ff.bright[6:0])
  ) else $error("checksum enable or brightness wrong");

  a_luma_low: assert property (
    lumaScale[1:0] == $past(st_ff.scaleLsb[1:0])
  ) else $error("luma scale low bits wrong");

  // End points of the shaping range; code 0 is also the reset value
  a_shape_low: assert property (
    $past(rstn && shapingFilterEn && st_ff.shape[3:0] == 4'h0)
      |-> shapingGain == -7'sh18
  ) else $error("shaping code 0 is not -4 dB");

  a_shape_high: assert property (
    $past(shapingFilterEn && st_ff.shape[3:0] == SHAPE_MAX_CODE)
      |-> shapingGain == 7'sh18
  ) else $error("shaping code 12 is not +4 dB");

  // Largest plain coring code and a mid code in noise reduction
  a_coring_max: assert property (
    $past(!noiseReductionMode && st_ff.coring[3:0] == CORING_MAX_CODE)
      |-> coringBorderGain == 6'sh08
  ) else $error("coring code 8 is not half gain");

  a_coring_nr_mid: assert property (
    $past(noiseReductionMode && st_ff.coring[7:4] == 4'h3)
      |-> coringDataGain == -6'sh06
  ) else $error("noise-reduction code 3 is not minus three eighths");

  // Accesses outside the mapped subaddress range
  sequence sUnmappedRd;
    regRdEn && (regAddr < OFS_CM_CTRL || regAddr > OFS_CORING);
  endsequence
  sequence sUnmappedWr;
    regWrEn && (regAddr < OFS_CM_CTRL || regAddr > OFS_CORING);
  endsequence

  a_read_data: assert property (
    regRdEn |=> regRdValid && regRdData == $past(rdMux(st_ff, regAddr))
  ) else $error("read answer missing or wrong");

  a_valid_pulse: assert property (
    !regRdEn |=> !regRdValid
  ) else $error("read valid without a read");

  a_unmapped_read: assert property (
    sUnmappedRd |=> regRdData == RD_UNMAPPED
  ) else $error("unmapped read returned data");

  a_unmapped_write: assert property (
    sUnmappedWr |=> $stable(regFile)
  ) else $error("unmapped write changed a register");

  // Reset clears the whole bank; checked through reset itself
  a_reset_clear: assert property (
    disable iff (1'b0) !rstn |=> regFile == {11{REG_RESET}} && !regRdValid
  ) else $error("reset left a register or the read strobe set");

endmodule : sdvp_regs

// ---- tb/tb.sv ----
// Self-checking testbench of the SD picture-adjust register bank
`timescale 1ns/10ps
module tb;
  import sdvp_pkg::*;

  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic        [7:0] regAddr = 8'h00;
  logic              regWrEn = 1'b0;
  logic        [7:0] regWrData = 8'h00;
  logic              regRdEn = 1'b0;
  logic        [7:0] regRdData;
  logic              regRdValid;
  logic              fieldOdd = 1'b0;
  logic              shapingFilterEn = 1'b0;
  logic              noiseReductionMode = 1'b0;
  logic              cmInsert, cmChecksumEn, wssInsert, wssBlank;
  logic       [19:0] cmPayload;
  logic       [13:0] wssPayload;
  logic        [9:0] lumaScale, cbScale, crScale;
  logic        [1:0] phaseLsb;
  logic        [7:0] hueAdjust;
  logic        [6:0] brightness;
  logic signed [6:0] shapingGain;
  logic signed [5:0] coringBorderGain, coringDataGain;
  int                numErrors = 0;
  int                samplesChecked = 0;
  logic        [7:0] offs [0:10];

  sdvp_regs sdvp_regs_i (.clk(clk), .rstn(rstn), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData(regRdData), .regRdValid(regRdValid), .fieldOdd(fieldOdd),
    .shapingFilterEn(shapingFilterEn),
    .noiseReductionMode(noiseReductionMode), .cmInsert(cmInsert),
    .cmChecksumEn(cmChecksumEn), .cmPayload(cmPayload),
    .wssInsert(wssInsert), .wssBlank(wssBlank), .wssPayload(wssPayload),
    .lumaScale(lumaScale), .cbScale(cbScale), .crScale(crScale),
    .phaseLsb(phaseLsb), .hueAdjust(hueAdjust), .brightness(brightness),
    .shapingGain(shapingGain), .coringBorderGain(coringBorderGain),
    .coringDataGain(coringDataGain));

  // Free-running 40 MHz clock
  always #12.5 clk = ~clk;

  task automatic end_of_test();
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  // Compare of read data, valid strobe folded into the top bit
  task automatic chkReg(input logic [8:0] got, input logic [8:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      numErrors++;
      $display("MISMATCH t=%0t rd got=%h exp=%h", $time, got, exp);
    end
  endtask : chkReg

  // Compare of a derived output, zero-extended to 20 bits
  task automatic chkOut(input logic [19:0] got, input logic [19:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      numErrors++;
      $display("MISMATCH t=%0t out got=%h exp=%h", $time, got, exp);
    end
  endtask : chkOut

  // Write strobe is left high so that calls in a row go back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regRdEn   = 1'b0;
    regWrEn   = 1'b1;
    regAddr   = a;
    regWrData = d;
  endtask : wr

  // Idle cycles, long enough for derived outputs to follow registers
  task automatic settle(input int n);
    repeat (n) begin
      @(negedge clk);
      regWrEn = 1'b0;
      regRdEn = 1'b0;
    end
  endtask : settle

  // Read strobe for one edge, data judged while valid stands
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    regWrEn = 1'b0;
    regRdEn = 1'b1;
    regAddr = a;
    @(negedge clk);
    regRdEn = 1'b0;
    chkReg({regRdValid, regRdData}, {1'b1, exp});
  endtask : rd

  task automatic t_reset();
    for (int i = 0; i < 11; i++) rd(offs[i], REG_RESET);
    rd(8'ha4, RD_UNMAPPED);
    chkOut(cmPayload, 20'h00000);
    chkOut({10'h000, lumaScale}, 20'h00000);
  endtask : t_reset

  // Back-to-back writes, unmapped writes, reserved bits of 0xa2 dropped
  task automatic t_rw();
    for (int i = 0; i < 11; i++) wr(offs[i], 8'ha5 ^ 8'(i));
    wr(8'ha4, 8'hff);
    wr(8'h98, 8'hff);
    settle(2);
    for (int i = 0; i < 11; i++)
      rd(offs[i], (i == 9) ? 8'h0c : (8'ha5 ^ 8'(i)));
    rd(8'ha4, RD_UNMAPPED);
    rd(8'h98, RD_UNMAPPED);
  endtask : t_rw

  // Odd field already set while the enables are written, so the
  // field-gate checks in the design see their whole sequence
  task automatic t_cm();
    fieldOdd = 1'b1;
    wr(OFS_CM_CTRL, 8'hab);
    wr(OFS_CM_MID, 8'hc7);
    wr(OFS_CM_LOW, 8'h3e);
    settle(3);
    chkOut({19'h0, cmInsert}, 20'h00001);
    chkOut(cmPayload, 20'hbc73e);
    chkOut({6'h00, wssPayload}, 20'h0073e);
    chkOut({18'h0, wssInsert, cmChecksumEn}, 20'h00002);
    fieldOdd = 1'b0;
    settle(3);
    chkOut({19'h0, cmInsert}, 20'h00000);
    wr(OFS_CM_CTRL, 8'h5b);
    fieldOdd = 1'b1;
    settle(3);
    chkOut({19'h0, cmInsert}, 20'h00000);
    chkOut({18'h0, wssInsert, cmChecksumEn}, 20'h00001);
    fieldOdd = 1'b0;
    settle(3);
    chkOut({19'h0, cmInsert}, 20'h00001);
  endtask : t_cm

  task automatic t_scale();
    wr(OFS_SCALE_LSB, 8'h9c);
    wr(OFS_LUMA_HI, 8'h81);
    wr(OFS_CB_HI, 8'h42);
    wr(OFS_CR_HI, 8'h24);
    wr(OFS_HUE, 8'h5a);
    wr(OFS_BRIGHT, 8'hc3);
    settle(3);
    chkOut({10'h000, lumaScale}, 20'h00204);
    chkOut({10'h000, cbScale}, 20'h0010b);
    chkOut({10'h000, crScale}, 20'h00091);
    chkOut({18'h0, phaseLsb}, 20'h00002);
    chkOut({12'h000, hueAdjust}, 20'h0005a);
    chkOut({12'h000, wssBlank, brightness}, 20'h000c3);
  endtask : t_scale

  // Every shaping code with the outside filter enable on and off
  task automatic t_shape();
    logic [6:0] e7;
    for (int c = 0; c < 16; c++) begin
      wr(OFS_SHAPE_GAIN, 8'(c));
      for (int en = 0; en < 2; en++) begin
        shapingFilterEn = en[0];
        settle(3);
        e7 = en[0] ? 7'((((c > 12) ? 12 : c) * 4) - 24) : 7'h00;
        chkOut({13'h0, shapingGain}, {13'h0, e7});
      end
    end
  endtask : t_shape

  // Every coring code for both fields, in and out of noise reduction
  task automatic t_coring();
    int         kb, kd;
    logic [5:0] eb, ed;
    for (int c = 0; c < 16; c++) begin
      wr(OFS_CORING, {4'((c + 3) % 16), 4'(c)});
      kb = (c > 8) ? 8 : c;
      kd = (((c + 3) % 16) > 8) ? 8 : ((c + 3) % 16);
      for (int m = 0; m < 2; m++) begin
        noiseReductionMode = m[0];
        settle(3);
        eb = m[0] ? 6'(-2 * kb) : 6'(kb);
        ed = m[0] ? 6'(-2 * kd) : 6'(kd);
        chkOut({14'h0, coringBorderGain}, {14'h0, eb});
        chkOut({14'h0, coringDataGain}, {14'h0, ed});
      end
    end
  endtask : t_coring

  // Main sequence: reset held for eight cycles, then the scenarios
  initial begin
    offs = '{OFS_CM_CTRL, OFS_CM_MID, OFS_CM_LOW, OFS_SCALE_LSB,
             OFS_LUMA_HI, OFS_CB_HI, OFS_CR_HI, OFS_HUE, OFS_BRIGHT,
             OFS_SHAPE_GAIN, OFS_CORING};
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    t_reset();
    t_rw();
    t_cm();
    t_scale();
    t_shape();
    t_coring();
    end_of_test();
  end

  // Watchdog, well beyond the few hundred cycles the scenarios need
  initial begin
    #(25 * 20000);
    numErrors++;
    end_of_test();
  end

endmodule : tb
